// ### hw/rx_status_word.sv
// Receive status word builder, status FIFO and receiver stop/start control
// Operation
// - Flag length mismatch against length/type field
// - Flag runt when frame under 64 bytes
// - Drop runt status unless pass-bad set
// - Flag multicast destination address
// - Reserved status bits always read zero
// - Flag frames over 1518 bytes, never truncate
// - Flag collision seen after collision window
// - Frame type when field above 1500
// - Flag watchdog expiry on overlong frame
// - Flag receive error seen during frame
// - Flag dribble bits: 4 MII, 3+ 10M
// - No dribble flag when late collision set
// - CRC flag on bad FCS or receive error
// - CRC flag meaningless for runt, late, watchdog
// - Single halted pulse once receiver stops
// - Error flag on underruns or status overrun
// - Receiver keeps running after error flag
// - Error summary is OR of 11,7,6,1
// - Frame byte count in bits 29:16
// - Flag address filtering failure
// - Flag broadcast destination address
`include "rx_status_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module rx_status_word #(
    parameter int DEPTH = 16,
    parameter logic [13:0] WDOG_LIMIT = `WDOG_BYTES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Frame events from the receive MAC
    input wire logic rx_sof_i,
    input wire logic rx_byte_valid_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic rx_eof_i,
    input wire logic rx_er_i,
    input wire logic rx_collision_i,
    input wire logic rx_crc_fail_i,
    input wire logic [2:0] rx_dribble_bits_i,
    input wire logic rx_speed_10_i,
    input wire logic rx_filter_fail_i,
    // Data FIFO side
    input wire logic rx_data_underrun_i,
    // Events
    output logic receiver_halted_pulse_o,
    output logic receiver_error_flag_o
);

    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        rx_status_pkg::rx_state_t st;
        logic receive_enable_bit;
        logic pass_bad;
        logic receiver_error_flag;
        logic receiver_halted_pulse;
        logic [13:0] cnt;
        logic mcast;
        logic bcast;
        logic [15:0] ltype;
        logic late;
        logic rxer;
        logic [DEPTH-1:0][31:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
        logic waitreq;
        logic pend_empty;
        logic [31:0] rdata;
    } state_t;

    state_t s;
    state_t next_s;

    logic [31:0] stat;
    logic push;
    logic [13:0] cnt_fin;
    logic [15:0] expect_len;
    logic runt;
    logic accept;
    logic done;
    logic full;
    logic empty;
    logic err_set;
    logic err_clr;

    function automatic logic [AW-1:0] idx(input logic [AW:0] p);
        return p[AW-1:0];
    endfunction

    assign full = (s.wp[AW] != s.rp[AW]) && (idx(s.wp) == idx(s.rp));
    assign empty = (s.wp == s.rp);
    assign accept = (avs_read_i || avs_write_i) && s.waitreq;
    assign done = (avs_read_i || avs_write_i) && !s.waitreq;

    // ==========================================================================
    // Next state
    always_comb begin
        next_s = s;
        next_s.receiver_halted_pulse = 1'b0;
        stat = 32'h0000_0000;
        push = 1'b0;
        cnt_fin = s.cnt;
        expect_len = 16'h0000;
        runt = 1'b0;
        err_set = 1'b0;
        err_clr = 1'b0;

        // Receiver control
        case (s.st)
            rx_status_pkg::RX_HALTED: begin
                if (s.receive_enable_bit) begin
                    next_s.st = rx_status_pkg::RX_IDLE;
                end
            end
            rx_status_pkg::RX_IDLE: begin
                if (!s.receive_enable_bit) begin
                    next_s.st = rx_status_pkg::RX_HALTED;
                    next_s.receiver_halted_pulse = 1'b1;
                end else if (rx_sof_i) begin
                    next_s.st = rx_status_pkg::RX_FRAME;
                    next_s.cnt = 14'h0000;
                    next_s.mcast = 1'b0;
                    next_s.bcast = 1'b1;
                    next_s.ltype = 16'h0000;
                    next_s.late = 1'b0;
                    next_s.rxer = 1'b0;
                end
            end
            rx_status_pkg::RX_FRAME: begin
                if (rx_byte_valid_i) begin
                    if (s.cnt == 14'h0000) begin
                        next_s.mcast = rx_byte_i[0];
                    end
                    if (s.cnt < `DEST_ADDR_BYTES && rx_byte_i != `BCAST_BYTE) begin
                        next_s.bcast = 1'b0;
                    end
                    if (s.cnt == `TYPE_HI_INDEX) begin
                        next_s.ltype[15:8] = rx_byte_i;
                    end
                    if (s.cnt == `TYPE_LO_INDEX) begin
                        next_s.ltype[7:0] = rx_byte_i;
                    end
                    if (s.cnt != 14'h3fff) begin
                        next_s.cnt = s.cnt + 14'h0001;
                    end
                end
                if (rx_collision_i && s.cnt >= `MIN_FRAME_BYTES) begin
                    next_s.late = 1'b1;
                end
                if (rx_er_i) begin
                    next_s.rxer = 1'b1;
                end
                if (rx_eof_i) begin
                    cnt_fin = next_s.cnt;
                    runt = cnt_fin < `MIN_FRAME_BYTES;
                    expect_len = next_s.ltype + `FRAME_OVERHEAD;
                    if (expect_len < {2'b00, `MIN_FRAME_BYTES}) begin
                        expect_len = {2'b00, `MIN_FRAME_BYTES};
                    end
                    stat[`ST_FILTER_FAIL] = rx_filter_fail_i;
                    stat[`ST_LEN_MSB:`ST_LEN_LSB] = cnt_fin;
                    stat[`ST_BCAST] = next_s.bcast && cnt_fin >= `DEST_ADDR_BYTES;
                    stat[`ST_LEN_ERR] = cnt_fin >= `HEADER_BYTES
                        && next_s.ltype <= `MAX_LEN_FIELD
                        && {2'b00, cnt_fin} != expect_len;
                    stat[`ST_RUNT] = runt;
                    stat[`ST_MCAST] = next_s.mcast && cnt_fin != 14'h0000;
                    stat[`ST_TOO_LONG] = cnt_fin > `MAX_FRAME_BYTES;
                    stat[`ST_LATE_COL] = next_s.late;
                    stat[`ST_FRAME_TYPE] = cnt_fin >= `HEADER_BYTES
                        && next_s.ltype > `MAX_LEN_FIELD;
                    stat[`ST_WDOG] = cnt_fin > WDOG_LIMIT;
                    stat[`ST_MII_ERR] = next_s.rxer;
                    stat[`ST_DRIBBLE] = !next_s.late && (rx_speed_10_i
                        ? rx_dribble_bits_i >= `DRIBBLE_10M
                        : rx_dribble_bits_i == `DRIBBLE_MII);
                    // Raw value kept; host ignores it for runt, late or watchdog frames
                    stat[`ST_CRC] = rx_crc_fail_i || next_s.rxer;
                    stat[`ST_ERR_SUM] = stat[`ST_RUNT] | stat[`ST_TOO_LONG]
                        | stat[`ST_LATE_COL] | stat[`ST_CRC];
                    push = !runt || s.pass_bad;
                    if (!s.receive_enable_bit) begin
                        next_s.st = rx_status_pkg::RX_HALTED;
                        next_s.receiver_halted_pulse = 1'b1;
                    end else begin
                        next_s.st = rx_status_pkg::RX_IDLE;
                    end
                end
            end
            default: begin
                next_s.st = rx_status_pkg::RX_HALTED;
            end
        endcase

        // Status FIFO write side
        if (push) begin
            if (full) begin
                err_set = 1'b1;
            end else begin
                next_s.mem[idx(s.wp)] = stat;
                next_s.wp = s.wp + 1'b1;
            end
        end
        if (rx_data_underrun_i) begin
            err_set = 1'b1;
        end

        // Bus slave: sample on the first cycle, complete on the next
        next_s.waitreq = !accept;
        if (accept && avs_read_i) begin
            case (avs_address_i)
                `REG_MAC_CONTROL: begin
                    next_s.rdata = `MAC_CONTROL_REGISTER_RESET;
                    next_s.rdata[`MAC_CONTROL_REGISTER_RECEIVE_ENABLE] = s.receive_enable_bit;
                    next_s.rdata[`MAC_CONTROL_REGISTER_PASS_BAD] = s.pass_bad;
                end
                `REG_RX_STATUS_PORT: begin
                    next_s.rdata = empty ? 32'h0000_0000 : s.mem[idx(s.rp)];
                    next_s.pend_empty = empty;
                end
                `REG_RX_CONTROL: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rdata[`CTRL_ERR_BIT] = s.receiver_error_flag;
                    next_s.rdata[`CTRL_HALTED_BIT] = (s.st == rx_status_pkg::RX_HALTED);
                    next_s.rdata[`CTRL_LEVEL_LSB +: 8] = 8'(s.wp - s.rp);
                end
                default: begin
                    next_s.rdata = 32'h0000_0000;
                end
            endcase
        end
        if (done && avs_read_i && avs_address_i == `REG_RX_STATUS_PORT) begin
            if (s.pend_empty) begin
                err_set = 1'b1;
            end else begin
                next_s.rp = s.rp + 1'b1;
            end
        end
        if (done && avs_write_i) begin
            case (avs_address_i)
                `REG_MAC_CONTROL: begin
                    if (avs_byteenable_i[0]) begin
                        next_s.receive_enable_bit = avs_writedata_i[`MAC_CONTROL_REGISTER_RECEIVE_ENABLE];
                    end
                    if (avs_byteenable_i[2]) begin
                        next_s.pass_bad = avs_writedata_i[`MAC_CONTROL_REGISTER_PASS_BAD];
                    end
                end
                `REG_RX_CONTROL: begin
                    if (avs_byteenable_i[0]) begin
                        err_clr = avs_writedata_i[`CTRL_ERR_BIT];
                        if (avs_writedata_i[`CTRL_FLUSH_BIT]
                            && s.st == rx_status_pkg::RX_HALTED) begin
                            next_s.wp = '0;
                            next_s.rp = '0;
                        end
                    end
                end
                default: begin
                    next_s.rdata = s.rdata;
                end
            endcase
        end

        // A new error wins over a clear in the same cycle
        next_s.receiver_error_flag = (s.receiver_error_flag && !err_clr) || err_set;
    end

    // ==========================================================================
    // State register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.st <= rx_status_pkg::RX_HALTED;
            s.bcast <= 1'b1;
            s.waitreq <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign avs_readdata_o = s.rdata;
    assign avs_waitrequest_o = s.waitreq;
    assign receiver_halted_pulse_o = s.receiver_halted_pulse;
    assign receiver_error_flag_o = s.receiver_error_flag;

    // ==========================================================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence idle_disabled;
        s.st == rx_status_pkg::RX_IDLE && !s.receive_enable_bit;
    endsequence

    sequence one_pulse;
        receiver_halted_pulse_o ##1 !receiver_halted_pulse_o;
    endsequence

    sequence frame_end;
        s.st == rx_status_pkg::RX_FRAME && rx_eof_i;
    endsequence

    a_reserved_zero: assert property (push |-> stat[31] == 1'b0 && stat[14] == 1'b0
        && stat[9:8] == 2'b00 && stat[0] == 1'b0)
        else $error("reserved status bit set");

    a_halt_pulse: assert property (idle_disabled |=> one_pulse)
        else $error("halt pulse missing or too long");

    a_halt_state: assert property ($rose(receiver_halted_pulse_o)
        |-> s.st == rx_status_pkg::RX_HALTED)
        else $error("halt pulse without halt");

    a_runt_drop: assert property (frame_end ##0 (runt && !s.pass_bad)
        |=> $stable(s.wp))
        else $error("runt status pushed");

    a_push_once: assert property (frame_end ##0 (!runt && !full)
        |=> s.wp == $past(s.wp) + 1'b1 ##1 s.st != rx_status_pkg::RX_FRAME)
        else $error("status word not pushed once");

    a_push_cause: assert property (push |-> s.st == rx_status_pkg::RX_FRAME && rx_eof_i)
        else $error("push outside frame end");

    a_overrun_err: assert property (push && full |=> receiver_error_flag_o)
        else $error("overrun not flagged");

    a_keep_running: assert property (receiver_error_flag_o && s.st == rx_status_pkg::RX_IDLE
        && s.receive_enable_bit && rx_sof_i |=> s.st == rx_status_pkg::RX_FRAME)
        else $error("receiver stalled by error");

    a_dribble_late: assert property (push && stat[`ST_LATE_COL] |-> !stat[`ST_DRIBBLE])
        else $error("dribble with late collision");

    a_type_runt: assert property (push && cnt_fin < `HEADER_BYTES
        |-> !stat[`ST_FRAME_TYPE])
        else $error("frame type set on short runt");

    a_err_summary: assert property (push |-> stat[`ST_ERR_SUM] == (runt
        || cnt_fin > `MAX_FRAME_BYTES || next_s.late || rx_crc_fail_i || next_s.rxer))
        else $error("error summary wrong");

    a_bus_answer: assert property (accept |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer timing wrong");

endmodule

`default_nettype wire

// ### hw/rx_status_regs.svh
// Register offsets, status word layout and frame limits of the receive status block
`ifndef RX_STATUS_REGS_SVH
`define RX_STATUS_REGS_SVH

// ==========================================================================
// Register byte offsets
`define REG_MAC_CONTROL 4'h0
`define REG_RX_STATUS_PORT 4'h4
`define REG_RX_CONTROL 4'h8

// ==========================================================================
// Register fields and reset values
`define MAC_CONTROL_REGISTER_RECEIVE_ENABLE 2
`define MAC_CONTROL_REGISTER_PASS_BAD 16
`define MAC_CONTROL_REGISTER_RESET 32'h0000_0000
`define CTRL_ERR_BIT 0
`define CTRL_FLUSH_BIT 1
`define CTRL_HALTED_BIT 1
`define CTRL_LEVEL_LSB 8

// ==========================================================================
// Status word fields
`define ST_FILTER_FAIL 30
`define ST_LEN_MSB 29
`define ST_LEN_LSB 16
`define ST_ERR_SUM 15
`define ST_BCAST 13
`define ST_LEN_ERR 12
`define ST_RUNT 11
`define ST_MCAST 10
`define ST_TOO_LONG 7
`define ST_LATE_COL 6
`define ST_FRAME_TYPE 5
`define ST_WDOG 4
`define ST_MII_ERR 3
`define ST_DRIBBLE 2
`define ST_CRC 1

// ==========================================================================
// Frame limits and field positions in bytes, dribble bit counts and the broadcast byte value
`define MIN_FRAME_BYTES 14'h0040
`define MAX_FRAME_BYTES 14'h05ee
`define MAX_LEN_FIELD 16'h05dc
`define HEADER_BYTES 14'h000e
`define FRAME_OVERHEAD 16'h0012
`define DEST_ADDR_BYTES 14'h0006
`define TYPE_HI_INDEX 14'h000c
`define TYPE_LO_INDEX 14'h000d
`define WDOG_BYTES 14'h0800
`define DRIBBLE_MII 3'h4
`define DRIBBLE_10M 3'h3
`define BCAST_BYTE 8'hff

`endif

// ### hw/rx_status_pkg.sv
// Types shared by the receive status block
package rx_status_pkg;

    // ==========================================================================
    // Receiver states
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_FRAME = 2'b01,
        RX_HALTED = 2'b10
    } rx_state_t;

endpackage

// ### verification/host_bus.sv
// Host bus master model for the Avalon-MM register port
`timescale 1ns/10ps
`default_nettype none

module host_bus (
    // Clock
    input wire logic clk_i,
    // Avalon-MM master
    output logic [3:0] address_o,
    output logic read_o,
    output logic write_o,
    output logic [3:0] byteenable_o,
    output logic [31:0] writedata_o,
    input wire logic [31:0] readdata_i,
    input wire logic waitrequest_i
);
    initial begin
        address_o = 4'h0;
        read_o = 1'b0;
        write_o = 1'b0;
        byteenable_o = 4'h0;
        writedata_o = 32'h0000_0000;
    end

    // ==========================================================================
    // One access, held until waitrequest is seen low at an edge
    task automatic access(input logic [3:0] a, input logic wr, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        @(posedge clk_i);
        address_o <= a;
        read_o <= !wr;
        write_o <= wr;
        writedata_o <= d;
        byteenable_o <= be;
        do @(posedge clk_i); while (waitrequest_i !== 1'b0);
        q = readdata_i;
        read_o <= 1'b0;
        write_o <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ### verification/rx_status_word_tb.sv
// Self-checking bench for the receive status word block
`timescale 1ns/10ps
`default_nettype none

module rx_status_word_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
    logic [31:0] readdata;
    logic waitrequest;
    logic rx_sof_i = 1'b0;
    logic rx_byte_valid_i = 1'b0;
    logic [7:0] rx_byte_i = 8'h00;
    logic rx_eof_i = 1'b0;
    logic rx_er_i = 1'b0;
    logic rx_collision_i = 1'b0;
    logic rx_crc_fail_i = 1'b0;
    logic [2:0] rx_dribble_bits_i = 3'h0;
    logic rx_speed_10_i = 1'b0;
    logic rx_filter_fail_i = 1'b0;
    logic rx_data_underrun_i = 1'b0;
    logic halted_pulse;
    logic error_flag;
    int miscompares = 0;
    int tests_run = 0;
    int pulses = 0;
    int cycles = 0;
    logic [31:0] q;

    always #5 clk_i = !clk_i;

    host_bus hb (.clk_i(clk_i), .address_o(address), .read_o(read), .write_o(write),
        .byteenable_o(byteenable), .writedata_o(writedata), .readdata_i(readdata),
        .waitrequest_i(waitrequest));

    rx_status_word #(.DEPTH(4), .WDOG_LIMIT(14'h0800)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .avs_address_i(address), .avs_read_i(read), .avs_write_i(write),
        .avs_byteenable_i(byteenable), .avs_writedata_i(writedata),
        .avs_readdata_o(readdata), .avs_waitrequest_o(waitrequest), .rx_sof_i(rx_sof_i),
        .rx_byte_valid_i(rx_byte_valid_i), .rx_byte_i(rx_byte_i), .rx_eof_i(rx_eof_i),
        .rx_er_i(rx_er_i), .rx_collision_i(rx_collision_i), .rx_crc_fail_i(rx_crc_fail_i),
        .rx_dribble_bits_i(rx_dribble_bits_i), .rx_speed_10_i(rx_speed_10_i),
        .rx_filter_fail_i(rx_filter_fail_i), .rx_data_underrun_i(rx_data_underrun_i),
        .receiver_halted_pulse_o(halted_pulse), .receiver_error_flag_o(error_flag));

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (halted_pulse === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (cycles == 30000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ==========================================================================
    // Shared helpers
    task automatic end_of_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        hb.access(a, 1'b1, d, be, q);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        hb.access(a, 1'b0, 32'h0000_0000, 4'hf, q);
        chk(q, exp);
    endtask

    function automatic logic [31:0] exp_word(int n, logic [7:0] d0, logic [15:0] ty,
        logic er, logic late, logic crc, logic [2:0] dr, logic s10, logic filt);
        logic runt;
        logic tl;
        logic crcb;
        logic le;
        logic ft;
        logic drib;
        runt = n < 64;
        tl = n > 1518;
        crcb = crc | er;
        ft = n >= 14 && ty > 16'h05dc;
        le = n >= 14 && !ft && n != ((ty + 18 > 64) ? ty + 18 : 64);
        drib = !late && (s10 ? dr >= 3'h3 : dr == 3'h4);
        return {1'b0, filt, 14'(n), runt | tl | late | crcb, 1'b0, d0 == 8'hff, le, runt,
            d0[0], 2'b00, tl, late, ft, n > 2048, er, drib, crcb, 1'b0};
    endfunction

    task automatic frame(int n, logic [7:0] d0, logic [15:0] ty, logic er, logic late,
        logic crc, logic [2:0] dr, logic s10, logic filt);
        @(posedge clk_i);
        rx_sof_i <= 1'b1;
        rx_crc_fail_i <= crc;
        rx_dribble_bits_i <= dr;
        rx_speed_10_i <= s10;
        rx_filter_fail_i <= filt;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            rx_sof_i <= 1'b0;
            rx_byte_valid_i <= 1'b1;
            rx_byte_i <= (i < 6) ? d0 : (i == 12) ? ty[15:8] : (i == 13) ? ty[7:0] : 8'(i);
            rx_er_i <= er && i == 20;
            rx_collision_i <= late && i == 70;
            rx_eof_i <= i == n - 1;
        end
        @(posedge clk_i);
        rx_byte_valid_i <= 1'b0;
        rx_eof_i <= 1'b0;
    endtask

    task automatic frame_chk(int n, logic [7:0] d0, logic [15:0] ty, logic er, logic late,
        logic crc, logic [2:0] dr, logic s10, logic filt);
        frame(n, d0, ty, er, late, crc, dr, s10, filt);
        rd_chk(4'h4, exp_word(n, d0, ty, er, late, crc, dr, s10, filt));
    endtask

    // ==========================================================================
    // Scenarios
    task automatic t_reset();
        rd_chk(4'h0, 32'h0000_0000);
        rd_chk(4'hc, 32'h0000_0000);
        rd_chk(4'h8, 32'h0000_0002);
        wr(4'h0, 32'h0000_0004, 4'h1);
    endtask

    task automatic t_fields();
        frame_chk(64, 8'h01, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
        frame_chk(64, 8'h00, 16'h002e, 0, 0, 0, 3'h0, 0, 0);
        frame_chk(64, 8'h00, 16'h0064, 0, 0, 0, 3'h0, 0, 0);
        frame_chk(80, 8'hff, 16'h05dc, 0, 0, 0, 3'h0, 0, 1);
        frame_chk(100, 8'h00, 16'h0800, 1, 0, 0, 3'h0, 0, 0);
        frame_chk(100, 8'h00, 16'h0800, 0, 1, 1, 3'h4, 0, 0);
        for (int i = 0; i < 16; i++) begin
            frame_chk(64, 8'h00, 16'h0800, 0, 0, 0, 3'(i), i[3], 0);
        end
    endtask

    task automatic t_runt_long();
        frame(20, 8'h00, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
        rd_chk(4'h8, 32'h0000_0000);
        wr(4'h0, 32'h0001_0000, 4'h4);
        frame_chk(20, 8'h00, 16'h0800, 0, 0, 1, 3'h0, 0, 0);
        frame_chk(13, 8'h00, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
        frame_chk(1519, 8'h00, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
        frame_chk(2049, 8'h00, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
    endtask

    task automatic t_halt();
        int p0;
        frame(64, 8'h00, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
        p0 = pulses;
        wr(4'h0, 32'h0000_0000, 4'h1);
        repeat (4) @(posedge clk_i);
        chk(32'(pulses - p0), 32'h0000_0001);
        rd_chk(4'h8, 32'h0000_0102);
        frame(64, 8'h00, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
        wr(4'h8, 32'h0000_0002, 4'h1);
        rd_chk(4'h8, 32'h0000_0002);
        wr(4'h0, 32'h0000_0004, 4'h1);
        rd_chk(4'h8, 32'h0000_0000);
        chk(32'(pulses - p0), 32'h0000_0001);
    endtask

    task automatic t_errors();
        rd_chk(4'h4, 32'h0000_0000);
        rd_chk(4'h8, 32'h0000_0001);
        frame_chk(64, 8'h00, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
        wr(4'h8, 32'h0000_0001, 4'h1);
        rd_chk(4'h8, 32'h0000_0000);
        chk({31'h0000_0000, error_flag}, 32'h0000_0000);
        @(posedge clk_i);
        rx_data_underrun_i <= 1'b1;
        @(posedge clk_i);
        rx_data_underrun_i <= 1'b0;
        rd_chk(4'h8, 32'h0000_0001);
        wr(4'h8, 32'h0000_0001, 4'h1);
        for (int i = 0; i < 5; i++) begin
            frame(64, 8'h00, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
        end
        rd_chk(4'h8, 32'h0000_0401);
        chk({31'h0000_0000, error_flag}, 32'h0000_0001);
        // Oldest four words drain in order; the fifth was dropped on overrun
        for (int i = 0; i < 4; i++) begin
            rd_chk(4'h4, exp_word(64, 8'h00, 16'h0800, 0, 0, 0, 3'h0, 0, 0));
        end
        frame_chk(64, 8'h01, 16'h0800, 0, 0, 0, 3'h0, 0, 0);
        chk({31'h0000_0000, error_flag}, 32'h0000_0001);
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_fields();
        t_runt_long();
        t_halt();
        t_errors();
        end_of_test();
    end
endmodule

`default_nettype wire
